// ### shared/swl_pkg.sv
// Purpose: Constants for the single-wire link symbol receiver
// Assumes: 10 MHz system clock
// Notes: Duty thresholds are eighths of the measured period
package swl_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] FAULT_MASK_ADDR = 8'h02;
  localparam logic [7:0] FAULT_MASK_RESET = 8'h1F;
  localparam int CHANNEL_BIT = 2;
  localparam int PARITY_BIT = 1;
  localparam int FRAME_BIT = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 100;
  localparam int ACTIVITY_TIMEOUT_US = 100000;
  localparam int ACTIVITY_TIMEOUT_CYC = ACTIVITY_TIMEOUT_US * 1000 / CLK_NS;
  localparam int MIN_PERIOD_CYC = 4;
  localparam int CNT_W = 16;
  localparam int PAYLOAD_BITS = 16;
  // ****************************************
  // Symbol classes
  // ****************************************
  typedef enum logic [2:0] {SYM_ZERO, SYM_ONE, SYM_IDLE, SYM_BAD} swl_sym_e;
endpackage

// ### hdl/swl_symbol_link.sv
// Purpose: Device side symbol layer of the single-wire link
// Assumes: Line input already latched and synchronous to mclk_in
// Notes: Decodes symbols, frames, gives acknowledge and flags inactivity
//
// Behaviour
// - Acknowledge spans two periods, master listens
// - Device pulls ack output low to acknowledge
// - Feedback drives receive line between midpoints
// - Fault flag asserted when activity stops
// - Channel enable in mask register 0x02
// - Input latch holds state until opposite impulse
// - DC link acknowledges on pull-down only
// - Acknowledge lasts twice the last parity symbol
// - Each symbol judged alone, no baud rate
// - Frame: idle, tag, 16 payload, 2 parity, idle
`timescale 1ns/1ps
module swl_symbol_link #(
  parameter int TIMEOUT_CYC = swl_pkg::ACTIVITY_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Link line after input buffer
  input wire logic link_in,
  input wire logic dc_coupled_in,
  // Register access
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // Outputs
  output logic [7:0] fault_report_mask_out,
  output logic fault_flag_n_out,
  output logic ack_pulldown_n_out,
  output logic latch_feedback_out,
  output logic latch_fb_oe_out,
  output logic frame_valid_out,
  output logic [16:0] frame_data_out,
  output logic parity_err_out
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {ST_HUNT, ST_BITS, ST_AWAIT_D} swl_fr_e;
  logic link_q;
  logic [swl_pkg::CNT_W-1:0] hi_q, hi_d, per_q, per_d, p0_q, p0_d, ack_q, ack_d;
  logic [31:0] idle_q, idle_d;
  swl_fr_e fr_q, fr_d;
  logic [4:0] nbits_q, nbits_d;
  logic [18:0] sh_q, sh_d;
  logic [7:0] mask_q, mask_d;
  logic fault_q, fault_d, ackp_q, ackp_d, fb_q, fb_d, fboe_q, fboe_d;
  logic fv_q, fv_d, perr_q, perr_d;
  logic [16:0] fdat_q, fdat_d;
  logic rise, sym_done, close_tick, close_evt;
  swl_pkg::swl_sym_e sym;

  // Symbol boundary is a rising edge: symbols all end low
  assign rise = link_in && !link_q;
  assign sym_done = rise && (per_q >= swl_pkg::CNT_W'(swl_pkg::MIN_PERIOD_CYC));
  // Closing idle ends by time: the acknowledge slot after it brings no edge
  assign close_tick = fr_q == ST_AWAIT_D && !link_in && hi_q >= swl_pkg::CNT_W'(2) &&
                      per_q == {hi_q[swl_pkg::CNT_W-2:0], 1'b0};
  assign close_evt = fr_q == ST_AWAIT_D && (sym_done || close_tick);

  // ****************************************
  // Symbol classifier
  // ****************************************
  // Duty measured against own period, eighths
  always_comb begin
    logic [swl_pkg::CNT_W+2:0] h8;
    h8 = {hi_q, 3'b000};
    sym = swl_pkg::SYM_BAD;
    if (h8 >= {3'b000, per_q} && h8 <= {2'b00, per_q, 1'b0} + {3'b000, per_q}) begin
      sym = swl_pkg::SYM_ZERO; // 1/8..3/8
    end else if (h8 >= {1'b0, per_q, 2'b00} - {3'b000, per_q} &&
                 h8 <= {1'b0, per_q, 2'b00} + {3'b000, per_q}) begin
      sym = swl_pkg::SYM_IDLE; // 3/8..5/8 exclusive ends
    end else if (h8 >= {1'b0, per_q, 2'b00} + {2'b00, per_q, 1'b0} + {3'b000, per_q} - {3'b000, per_q} &&
                 h8 <= {per_q, 3'b000} - {3'b000, per_q}) begin
      sym = swl_pkg::SYM_ONE; // 6/8..7/8
    end
    if (h8 == {2'b00, per_q, 1'b0} + {3'b000, per_q} ||
        h8 == {1'b0, per_q, 2'b00} + {3'b000, per_q}) begin
      sym = swl_pkg::SYM_BAD; // Exact 3/8 and 5/8 edges rejected
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    hi_d = hi_q;
    per_d = per_q;
    p0_d = p0_q;
    ack_d = ack_q;
    idle_d = idle_q;
    fr_d = fr_q;
    nbits_d = nbits_q;
    sh_d = sh_q;
    mask_d = mask_q;
    fv_d = 1'b0;
    perr_d = perr_q;
    fdat_d = fdat_q;
    ackp_d = 1'b1;
    fb_d = fb_q;
    fboe_d = 1'b0;
    // Register write
    if (reg_wr_in && reg_addr_in == swl_pkg::FAULT_MASK_ADDR) begin
      mask_d = reg_wdata_in;
    end
    // Period and high-time counters, saturating
    if (rise) begin
      per_d = swl_pkg::CNT_W'(1);
      hi_d = swl_pkg::CNT_W'(1);
    end else begin
      if (per_q != '1) per_d = per_q + 1'b1;
      if (link_in && hi_q != '1) hi_d = hi_q + 1'b1;
    end
    // Activity watchdog; quiet line counts as inactive
    if ((sym_done && sym != swl_pkg::SYM_BAD) || close_tick) idle_d = '0;
    else if (idle_q < 32'(TIMEOUT_CYC)) idle_d = idle_q + 32'd1;
    // Frame assembly
    if (sym_done || close_tick) begin
      case (fr_q)
        ST_HUNT: begin
          if (sym == swl_pkg::SYM_IDLE) begin
            fr_d = ST_BITS;
            nbits_d = '0;
          end
        end
        ST_BITS: begin
          if (sym == swl_pkg::SYM_IDLE) begin
            nbits_d = '0; // Restart from tag bit
          end else if (sym == swl_pkg::SYM_BAD) begin
            fr_d = ST_HUNT;
          end else begin
            sh_d = {sh_q[17:0], sym == swl_pkg::SYM_ONE};
            nbits_d = nbits_q + 5'd1;
            if (nbits_q == 5'(swl_pkg::PAYLOAD_BITS + 2)) begin
              fr_d = ST_AWAIT_D;
              p0_d = per_q; // Last parity symbol length
            end
          end
        end
        ST_AWAIT_D: begin
          if (close_tick || sym == swl_pkg::SYM_IDLE) begin
            fr_d = ST_BITS;
            nbits_d = '0;
            fv_d = 1'b1;
            fdat_d = sh_q[18:2];
            perr_d = (sh_q[1] != ~^sh_q[18:10]) || (sh_q[0] != ~^sh_q[9:2]);
            if (!((sh_q[1] != ~^sh_q[18:10]) || (sh_q[0] != ~^sh_q[9:2]))) begin
              ack_d = {p0_q[swl_pkg::CNT_W-2:0], 1'b0}; // Two periods
            end
          end else begin
            fr_d = ST_HUNT;
          end
        end
        default: fr_d = ST_HUNT;
      endcase
    end
    // Acknowledge window after closing idle
    if (ack_q != '0 && !close_evt) begin
      ack_d = ack_q - 1'b1;
      ackp_d = 1'b0; // Pull-down reverses flow, DC links too
      // Feedback high between midpoints of the two periods
      fboe_d = !dc_coupled_in;
      fb_d = (ack_q <= {1'b0, p0_q[swl_pkg::CNT_W-1:1]} + p0_q) &&
             (ack_q > {1'b0, p0_q[swl_pkg::CNT_W-1:1]});
    end else if (!(ack_q != '0)) begin
      fb_d = link_in; // Latch feedback follows input latch
    end
  end

  // Fault flag gated by channel enable bit
  always_comb begin
    fault_d = mask_q[swl_pkg::CHANNEL_BIT] && (idle_q >= 32'(TIMEOUT_CYC));
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      link_q <= 1'b0;
      hi_q <= '0;
      per_q <= '0;
      p0_q <= '0;
      ack_q <= '0;
      idle_q <= '0;
      fr_q <= ST_HUNT;
      nbits_q <= '0;
      sh_q <= '0;
      mask_q <= swl_pkg::FAULT_MASK_RESET;
      fault_q <= 1'b0;
      ackp_q <= 1'b1;
      fb_q <= 1'b0;
      fboe_q <= 1'b0;
      fv_q <= 1'b0;
      perr_q <= 1'b0;
      fdat_q <= '0;
    end else begin
      link_q <= link_in;
      hi_q <= hi_d;
      per_q <= per_d;
      p0_q <= p0_d;
      ack_q <= ack_d;
      idle_q <= idle_d;
      fr_q <= fr_d;
      nbits_q <= nbits_d;
      sh_q <= sh_d;
      mask_q <= mask_d;
      fault_q <= fault_d;
      ackp_q <= ackp_d;
      fb_q <= fb_d;
      fboe_q <= fboe_d;
      fv_q <= fv_d;
      perr_q <= perr_d;
      fdat_q <= fdat_d;
    end
  end

  // Outputs straight from flip-flops, fault flag through an inverter
  assign fault_report_mask_out = mask_q;
  assign fault_flag_n_out = !fault_q;
  assign ack_pulldown_n_out = ackp_q;
  assign latch_feedback_out = fb_q;
  assign latch_fb_oe_out = fboe_q;
  assign frame_valid_out = fv_q;
  assign frame_data_out = fdat_q;
  assign parity_err_out = perr_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_good_close;
    fr_q == ST_AWAIT_D && (close_tick || (sym_done && sym == swl_pkg::SYM_IDLE));
  endsequence

  mask_reset_val_a: assert property (@(posedge mclk_in) $fell(rst_in) |-> mask_q == 8'h1F)
    else $error("mask reset value wrong");
  mask_write_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    reg_wr_in && reg_addr_in == 8'h02 |=> fault_report_mask_out == $past(reg_wdata_in))
    else $error("mask write lost");
  fault_gate_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !mask_q[2] && !$past(mask_q[2]) |=> fault_flag_n_out)
    else $error("fault raised while channel masked");
  fault_raise_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    mask_q[2] && idle_q >= 32'(TIMEOUT_CYC) |=> !fault_flag_n_out)
    else $error("inactivity not flagged");
  frame_valid_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_good_close |=> frame_valid_out)
    else $error("frame not delivered");
  ack_len_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_good_close and !perr_d) |=> ack_q == {p0_q[swl_pkg::CNT_W-2:0], 1'b0})
    else $error("acknowledge length wrong");
  ack_pull_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ack_q != '0 && !close_evt |=> !ack_pulldown_n_out)
    else $error("pull-down not asserted");
  fb_drive_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    ack_q != '0 && !close_evt && !dc_coupled_in |=> latch_fb_oe_out)
    else $error("feedback not driven during acknowledge");
  idle_restart_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    sym_done && fr_q == ST_BITS && sym == swl_pkg::SYM_IDLE |=> nbits_q == 5'd0)
    else $error("idle did not restart");
  bad_sym_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    sym_done && fr_q == ST_BITS && sym == swl_pkg::SYM_BAD |=> fr_q == ST_HUNT)
    else $error("bad symbol accepted");
endmodule

// ### verif/swl_master_model.sv
// Purpose: Master end of the link, drives symbols
// Assumes: Times in clock cycles, 16-cycle data symbols
// Notes: Line stays low between frames
`timescale 1ns/1ps
module swl_master_model #(
  parameter bit OPTO = 1'b0
) (
  // Clock
  input wire logic mclk_in,
  // Line toward the device and its direction control
  output logic link_out,
  output logic tx_en_n_out,
  // Acknowledge seen on the receive side
  input wire logic ack_n_in
);
  // Cycles in which an acknowledge was heard
  int heard = 0;
  logic tx = 1'h0;
  // Line rests low, driver enabled
  initial begin
    link_out = 1'h0;
    tx_en_n_out = 1'h0;
  end
  // One symbol: high part first, ends low
  task automatic sym(input int hi, input int per);
    for (int i = 0; i < per; i++) begin
      @(posedge mclk_in);
      #1 tx_en_n_out = 1'h0;
      tx = (i < hi) ^ OPTO; // Pre-inverted for an inverting isolator
      link_out = tx ^ OPTO;
    end
  endtask
  // Acknowledge slot: release, listen, drive again at its end
  task automatic ack_slot(input int per);
    for (int i = 0; i < per; i++) begin
      @(posedge mclk_in);
      #1 tx_en_n_out = (i < per - 1);
      link_out = 1'h0; // Device latch rests low
      if (tx_en_n_out) heard += (ack_n_in === 1'h0);
    end
  endtask
  // Data symbol at 25% or 75% high
  task automatic bit_sym(input logic b);
    sym(b ? 12 : 4, 16);
  endtask
  // Whole frame, optional parity slip, idle filler
  task automatic frame(input logic [16:0] w, input logic bad);
    sym(8, 16);
    for (int i = 16; i >= 0; i--) bit_sym(w[i]);
    bit_sym(~^w[16:8]);
    bit_sym((~^w[7:0]) ^ bad);
    sym(8, 16);
    ack_slot(32); // Twice the last parity period
    sym(8, 16);
    sym(0, 48);
  endtask
endmodule

// ### verif/tb.sv
// Purpose: Self-checking bench of the symbol link
// Assumes: Master model drives the line
// Notes: Short inactivity timeout for simulation
`timescale 1ns/1ps
module tb;
  localparam int TO = 200;
  logic mclk_in = 1'h0;
  logic rst_in = 1'h1;
  logic link;
  logic dc = 1'h0;
  logic wr = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] mask;
  logic flt_n, ack_n, fb, oe, fv, perr;
  logic [16:0] fdata;
  int n_fail = 0;
  int n_compared = 0;
  int frames = 0;
  int ack_cyc = 0;
  int oe_cyc = 0;
  int fb_cyc = 0;
  int cyc = 0;
  swl_master_model #(.OPTO(1'b1)) m (
    .mclk_in(mclk_in), .link_out(link), .tx_en_n_out(), .ack_n_in(ack_n)
  );
  swl_symbol_link #(.TIMEOUT_CYC(TO)) dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .link_in(link), .dc_coupled_in(dc),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .fault_report_mask_out(mask), .fault_flag_n_out(flt_n),
    .ack_pulldown_n_out(ack_n), .latch_feedback_out(fb),
    .latch_fb_oe_out(oe), .frame_valid_out(fv),
    .frame_data_out(fdata), .parity_err_out(perr)
  );
  // Clock
  initial forever #50 mclk_in = ~mclk_in;
  // Event counts and hang guard
  always @(posedge mclk_in) begin
    cyc++;
    frames += (fv === 1'h1);
    ack_cyc += (ack_n === 1'h0);
    oe_cyc += (oe === 1'h1);
    fb_cyc += (oe === 1'h1 && fb === 1'h1);
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // Compare design values
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Compare event counts
  task automatic chk_n(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1 wr = 1'h1;
    addr = a;
    wdata = d;
    @(posedge mclk_in);
    #1 wr = 1'h0;
    @(posedge mclk_in);
  endtask
  // Values right after reset, then writes
  task automatic t_regs();
    chk(17'(mask), 17'h0001F);
    chk({flt_n, ack_n, oe, fv}, 17'h0000C);
    wr_reg(8'h03, 8'h00);
    chk(17'(mask), 17'h0001F);
    wr_reg(swl_pkg::FAULT_MASK_ADDR, 8'hA5);
    chk(17'(mask), 17'h000A5);
    wr_reg(swl_pkg::FAULT_MASK_ADDR, swl_pkg::FAULT_MASK_RESET);
    $display("test regs done");
  endtask
  // One frame with ack and feedback checks
  task automatic t_frame(input logic [16:0] w, input logic bad, input logic d);
    @(posedge mclk_in);
    #1 dc = d;
    frames = 0;
    ack_cyc = 0;
    oe_cyc = 0;
    fb_cyc = 0;
    m.heard = 0;
    m.frame(w, bad);
    chk_n(frames, 1);
    chk(fdata, w);
    chk(17'(perr), 17'(bad));
    chk_n(ack_cyc, bad ? 0 : 32);
    chk_n(oe_cyc > 0, !bad && !d);
    chk_n(fb_cyc, (!bad && !d) ? 16 : 0);
    chk_n(m.heard > 0, !bad);
    $display("test frame %h done", w);
  endtask
  // Partial frame cut by a fresh idle
  task automatic t_restart();
    frames = 0;
    m.sym(8, 16);
    for (int i = 0; i < 6; i++) m.bit_sym(i[0]);
    m.frame(17'h0C3A5, 1'h0);
    chk_n(frames, 1);
    chk(fdata, 17'h0C3A5);
    $display("test restart done");
  endtask
  // Quiet line with channel bit off, then on
  task automatic t_fault();
    wr_reg(swl_pkg::FAULT_MASK_ADDR, 8'h1B);
    m.sym(0, TO + 100);
    chk(17'(flt_n), 17'h00001);
    wr_reg(swl_pkg::FAULT_MASK_ADDR, swl_pkg::FAULT_MASK_RESET);
    m.sym(0, TO + 100);
    chk(17'(flt_n), 17'h00000);
    $display("test fault done");
  endtask
  // Counts and verdict
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    #1 rst_in = 1'h0;
    t_regs();
    t_frame(17'h1A55A, 1'h0, 1'h0);
    t_frame(17'h00001, 1'h1, 1'h0);
    t_frame(17'h1F00F, 1'h0, 1'h1);
    t_restart();
    t_fault();
    end_sim();
  end
endmodule
